// file: design/bbc_defines.vh
`ifndef BBC_DEFINES_VH
`define BBC_DEFINES_VH
// operation selects
`define BBC_OP_NONE 2'h0
`define BBC_OP_CARRY_CLEAR 2'h1
`define BBC_OP_SIGNED_GT 2'h2
`define BBC_OP_SIGNED_LE 2'h3
// operand addressing forms of the bit-clear instruction
`define BBC_MODE_DIR 3'h0
`define BBC_MODE_EXT 3'h1
`define BBC_MODE_IDX 3'h2
`define BBC_MODE_IDX1 3'h3
`define BBC_MODE_IDX2 3'h4
`define BBC_MODE_IND_D 3'h5
`define BBC_MODE_IND_IDX2 3'h6
// mask byte offsets from the opcode address
`define BBC_MASK_OFS_SHORT 16'h0002
`define BBC_MASK_OFS_MID 16'h0003
`define BBC_MASK_OFS_LONG 16'h0004
// branch target base offset
`define BBC_BRANCH_BASE 16'h0002
// queue refill cycles
`define BBC_TAKEN_CYCLES 2'h3
`define BBC_UNTAKEN_CYCLES 2'h1
// condition code bit positions (s x h i n z v c)
`define BBC_CCR_C 0
`define BBC_CCR_V 1
`define BBC_CCR_Z 2
`define BBC_CCR_N 3
// reset values
`define BBC_PC_RESET 16'h0000
`define BBC_CCR_RESET 8'h00
`endif

// file: design/bbc_exec.v
`timescale 1ns/100ps
`include "bbc_defines.vh"
// Notes on behaviour
// - carry-clear branch is taken only when carry is zero, else falls through
// - taken branch target is pc plus two plus sign-extended 8-bit offset
// - taken branch spends three refill cycles, untaken one fetch cycle
// - signed greater taken when z or (n xor v) is 0; less-equal when 1
// - bit-clear writes operand and inverted mask back
// - operand bits under zero mask bits are kept as read
// - mask byte address on MASK_ADDR is pc plus 2, 3 or 4 by addressing form; the mask itself comes in on BC_MASK
// - after bit-clear n copies result msb, v clears, c and s x h i keep
// - after bit-clear z is set when the 8-bit result is zero
// - bit-clear refuses the indirect indexed addressing forms
module bbc_exec (
  // clock and reset
  input wire CLOCK,
  input wire NRST,
  // branch request
  input wire BR_START,
  input wire [1:0] BR_OP,
  input wire [7:0] BR_OFFSET,
  // bit-clear request
  input wire BC_START,
  input wire [2:0] BC_MODE,
  input wire [15:0] BC_ADDR,
  input wire [7:0] BC_MASK,
  // program counter and condition codes seen by the block
  input wire [15:0] PC_IN,
  input wire [7:0] CCR_IN,
  // memory read data
  input wire [7:0] MEM_RDATA,
  // results
  output reg [15:0] PC_OUT,
  output reg [7:0] CCR_OUT,
  output reg DONE,
  output reg BUSY,
  output reg BR_TAKEN,
  output reg ILLEGAL,
  output reg [15:0] MASK_ADDR,
  // memory access
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [15:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  output reg QUEUE_FETCH
);

  // sequencer states; the write waits one idle cycle for read data
  localparam ST_IDLE = 3'h0;
  localparam ST_REFILL = 3'h1;
  localparam ST_READ = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_WRITE = 3'h4;

  // mask is captured at the start, but BC_ADDR and CCR_IN are read later, so the caller must hold them
  reg [2:0] state_reg;
  reg [1:0] cnt_reg;
  reg [7:0] mask_reg;
  reg [7:0] result;
  reg take;

  // branch decision from the condition codes
  function cond_true;
    input [1:0] op;
    input [7:0] ccr;
    reg nzv;
    begin
      nzv = ccr[`BBC_CCR_Z] | (ccr[`BBC_CCR_N] ^ ccr[`BBC_CCR_V]);
      case (op)
        `BBC_OP_CARRY_CLEAR: cond_true = ~ccr[`BBC_CCR_C];
        `BBC_OP_SIGNED_GT: cond_true = ~nzv;
        `BBC_OP_SIGNED_LE: cond_true = nzv;
        default: cond_true = 1'b0;
      endcase
    end
  endfunction

  // mask byte location depends on the operand's instruction length
  function [15:0] mask_offset;
    input [2:0] mode;
    begin
      case (mode)
        `BBC_MODE_EXT: mask_offset = `BBC_MASK_OFS_MID;
        `BBC_MODE_IDX1: mask_offset = `BBC_MASK_OFS_MID;
        `BBC_MODE_IDX2: mask_offset = `BBC_MASK_OFS_LONG;
        default: mask_offset = `BBC_MASK_OFS_SHORT;
      endcase
    end
  endfunction

  // indirect forms are outside the legal set
  function mode_legal;
    input [2:0] mode;
    begin
      mode_legal = (mode <= `BBC_MODE_IDX2);
    end
  endfunction

  // next pc of a two-byte branch, taken or falling through
  function [15:0] branch_pc;
    input [15:0] pc;
    input [7:0] ofs;
    input taken;
    begin
      // the offset is signed, so a set top bit jumps backwards
      if (taken) begin
        branch_pc = pc + `BBC_BRANCH_BASE + {{8{ofs[7]}}, ofs};
      end else begin
        branch_pc = pc + `BBC_BRANCH_BASE;
      end
    end
  endfunction

  // flags after a bit-clear; carry and the control bits pass through
  function [7:0] clear_flags;
    input [7:0] ccr;
    input [7:0] res;
    begin
      clear_flags = ccr;
      clear_flags[`BBC_CCR_N] = res[7];
      clear_flags[`BBC_CCR_V] = 1'b0;
      clear_flags[`BBC_CCR_Z] = (res == 8'h00);
    end
  endfunction

  // masked result; mask zeros pass operand bits through untouched
  always @* begin
    result = MEM_RDATA & ~mask_reg;
    take = cond_true(BR_OP, CCR_IN);
  end

  // sequencer; a new request is only taken while idle
  // requests that arrive while busy are dropped, not queued, so the
  // caller has to wait for done before it asks again
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      mask_reg <= 8'h00;
      PC_OUT <= `BBC_PC_RESET;
      CCR_OUT <= `BBC_CCR_RESET;
      DONE <= 1'b0;
      BUSY <= 1'b0;
      BR_TAKEN <= 1'b0;
      ILLEGAL <= 1'b0;
      MASK_ADDR <= 16'h0000;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
      QUEUE_FETCH <= 1'b0;
    end else begin
      DONE <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      QUEUE_FETCH <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          ILLEGAL <= 1'b0;
          if (BR_START && BR_OP != `BBC_OP_NONE) begin
            BUSY <= 1'b1;
            BR_TAKEN <= take;
            CCR_OUT <= CCR_IN;
            QUEUE_FETCH <= 1'b1;
            // pc is the opcode address of the two-byte branch
            PC_OUT <= branch_pc(PC_IN, BR_OFFSET, take);
            if (take) begin
              // the first of the refill fetches is issued right here
              cnt_reg <= `BBC_TAKEN_CYCLES - 2'h1;
              state_reg <= ST_REFILL;
            end else begin
              cnt_reg <= `BBC_UNTAKEN_CYCLES - 2'h1;
              state_reg <= ST_REFILL;
            end
          end else if (BC_START) begin
            if (mode_legal(BC_MODE)) begin
              BUSY <= 1'b1;
              mask_reg <= BC_MASK;
              MASK_ADDR <= PC_IN + mask_offset(BC_MODE);
              state_reg <= ST_READ;
            end else begin
              // refused: no memory access, flags untouched
              ILLEGAL <= 1'b1;
              DONE <= 1'b1;
              CCR_OUT <= CCR_IN;
            end
          end
        end
        ST_REFILL: begin
          // one fetch pulse per refill cycle, counted down
          if (cnt_reg == 2'h0) begin
            BUSY <= 1'b0;
            DONE <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            QUEUE_FETCH <= 1'b1;
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        ST_READ: begin
          MEM_RD <= 1'b1;
          MEM_ADDR <= BC_ADDR;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // read data is valid the cycle after the read strobe
          // a slower memory would need this state stretched
          state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          MEM_WR <= 1'b1;
          MEM_WDATA <= result;
          // flags come from the value written, never from the read value
          CCR_OUT <= clear_flags(CCR_IN, result);
          BUSY <= 1'b0;
          DONE <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: tb/bbc_exec_properties.sv
`timescale 1ns/100ps
module bbc_chk (
  // clock and reset
  input wire CLOCK,
  input wire NRST,
  // requests
  input wire BR_START,
  input wire BC_START,
  input wire [1:0] BR_OP,
  input wire [2:0] BC_MODE,
  input wire [7:0] BR_OFFSET,
  input wire [7:0] BC_MASK,
  input wire [15:0] PC_IN,
  input wire [7:0] CCR_IN,
  input wire [7:0] MEM_RDATA,
  // results
  input wire BUSY,
  input wire DONE,
  input wire BR_TAKEN,
  input wire ILLEGAL,
  input wire [15:0] PC_OUT,
  input wire [7:0] CCR_OUT,
  input wire [15:0] MASK_ADDR,
  // memory side
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [15:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  input wire QUEUE_FETCH
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // accepted requests; a branch wins a collision
  wire br = BR_START && !BUSY && BR_OP != 2'h0;
  wire bc = BC_START && !br && !BUSY;
  wire [15:0] tgt = PC_IN + 16'h0002 + {{8{BR_OFFSET[7]}}, BR_OFFSET};
  wire sg = (CCR_IN[2] | (CCR_IN[3] ^ CCR_IN[1])) == BR_OP[0];
  wire [15:0] mo = (BC_MODE == 3'h4) ? 16'h0004 :
    (BC_MODE == 3'h1 || BC_MODE == 3'h3) ? 16'h0003 : 16'h0002;
  wire [15:0] ma = PC_IN + mo;
  a_carry_clear: assert property (
    br && BR_OP == 2'h1 |-> ##2 BR_TAKEN == !$past(CCR_IN[0], 2))
    else $error("carry clear decision wrong");
  a_branch_target: assert property (
    br ##2 BR_TAKEN |-> PC_OUT == $past(tgt, 2))
    else $error("branch target wrong");
  a_taken_refill: assert property (
    br ##1 BR_TAKEN |-> QUEUE_FETCH [*3] ##1 DONE && !QUEUE_FETCH)
    else $error("taken refill timing wrong");
  a_untaken_fetch: assert property (
    br ##1 !BR_TAKEN |-> QUEUE_FETCH ##1 DONE && !QUEUE_FETCH)
    else $error("untaken fetch timing wrong");
  a_signed_pair: assert property (
    br && BR_OP[1] |-> ##2 BR_TAKEN == $past(sg, 2))
    else $error("signed branch decision wrong");
  a_branch_ccr: assert property (
    br |-> ##2 CCR_OUT == $past(CCR_IN, 2))
    else $error("branch altered flags");
  a_clear_data: assert property (
    bc && BC_MODE < 3'h5 |-> ##4 MEM_WR && DONE &&
    MEM_WDATA == ($past(MEM_RDATA) & ~$past(BC_MASK, 4)))
    else $error("bit clear write data wrong");
  a_clear_flags: assert property (
    MEM_WR |-> CCR_OUT == {$past(CCR_IN[7:4]), MEM_WDATA[7],
    MEM_WDATA == 8'h00, 1'b0, $past(CCR_IN[0])})
    else $error("bit clear flags wrong");
  a_mask_addr: assert property (
    bc && BC_MODE < 3'h5 |-> ##2 MASK_ADDR == $past(ma, 2))
    else $error("mask address wrong");
  a_refuse_ind: assert property (
    bc && BC_MODE > 3'h4 |-> ##1 ILLEGAL && DONE && !BUSY ##1
    !MEM_RD && !MEM_WR)
    else $error("indirect form not refused");
  a_one_access: assert property (
    MEM_RD |-> ##1 !MEM_RD && !MEM_WR ##1 MEM_WR &&
    MEM_ADDR == $past(MEM_ADDR, 2))
    else $error("bit clear access pattern wrong");
endmodule
bind bbc_exec bbc_chk u_chk (
  .CLOCK(CLOCK),
  .NRST(NRST),
  .BR_START(BR_START),
  .BC_START(BC_START),
  .BR_OP(BR_OP),
  .BC_MODE(BC_MODE),
  .BR_OFFSET(BR_OFFSET),
  .BC_MASK(BC_MASK),
  .PC_IN(PC_IN),
  .CCR_IN(CCR_IN),
  .MEM_RDATA(MEM_RDATA),
  .BUSY(BUSY),
  .DONE(DONE),
  .BR_TAKEN(BR_TAKEN),
  .ILLEGAL(ILLEGAL),
  .PC_OUT(PC_OUT),
  .CCR_OUT(CCR_OUT),
  .MASK_ADDR(MASK_ADDR),
  .MEM_RD(MEM_RD),
  .MEM_WR(MEM_WR),
  .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA),
  .QUEUE_FETCH(QUEUE_FETCH)
);

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "bbc_defines.vh"
module tb_top;
  reg CLOCK = 1'b0, NRST = 1'b0, BR_START = 1'b0, BC_START = 1'b0;
  reg [1:0] BR_OP = 2'h0;
  reg [2:0] BC_MODE = 3'h0;
  reg [7:0] BR_OFFSET = 8'h00, BC_MASK = 8'h00, CCR_IN = 8'h00;
  reg [7:0] MEM_RDATA = 8'h00, rd = 8'h00, wd;
  reg [15:0] BC_ADDR = 16'h0000, PC_IN = 16'h0000;
  wire [15:0] PC_OUT, MASK_ADDR, MEM_ADDR;
  wire [7:0] CCR_OUT, MEM_WDATA;
  wire DONE, BUSY, BR_TAKEN, ILLEGAL, MEM_RD, MEM_WR, QUEUE_FETCH;
  integer error_cnt = 0, checked = 0, qf, wr, rdc, i;
  bbc_exec u_dut (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .BR_START(BR_START),
    .BR_OP(BR_OP),
    .BR_OFFSET(BR_OFFSET),
    .BC_START(BC_START),
    .BC_MODE(BC_MODE),
    .BC_ADDR(BC_ADDR),
    .BC_MASK(BC_MASK),
    .PC_IN(PC_IN),
    .CCR_IN(CCR_IN),
    .MEM_RDATA(MEM_RDATA),
    .PC_OUT(PC_OUT),
    .CCR_OUT(CCR_OUT),
    .DONE(DONE),
    .BUSY(BUSY),
    .BR_TAKEN(BR_TAKEN),
    .ILLEGAL(ILLEGAL),
    .MASK_ADDR(MASK_ADDR),
    .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR),
    .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA),
    .QUEUE_FETCH(QUEUE_FETCH)
  );
  initial forever #10 CLOCK = ~CLOCK;
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked = checked + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // read data shows junk until the read strobe is seen, so early sampling
  // inside the block cannot pass by luck
  task go(input logic b);
    integer n;
    n = 0;
    qf = 0;
    wr = 0;
    rdc = 0;
    // one idle edge between requests, so no strobe is set twice at once
    @(negedge CLOCK);
    MEM_RDATA = ~rd;
    BR_START = b;
    BC_START = !b;
    @(negedge CLOCK);
    BR_START = 1'b0;
    BC_START = 1'b0;
    while (DONE !== 1'b1 && n < 12) begin
      qf = qf + QUEUE_FETCH;
      wr = wr + MEM_WR;
      rdc = rdc + MEM_RD;
      if (MEM_RD === 1'b1) MEM_RDATA = rd;
      @(negedge CLOCK);
      n = n + 1;
    end
    qf = qf + QUEUE_FETCH;
    wr = wr + MEM_WR;
    wd = MEM_WDATA;
    chk("done", DONE, 1'b1);
    chk("busy", BUSY, 1'b0);
  endtask
  initial begin
    repeat (12) @(negedge CLOCK);
    chk("pc reset", PC_OUT, 16'h0000);
    NRST = 1'b1;
    // carry clear: backward jump at the offset limit, then fall through
    PC_IN = 16'h1000;
    BR_OFFSET = 8'h80;
    BR_OP = `BBC_OP_CARRY_CLEAR;
    for (i = 0; i < 2; i = i + 1) begin
      CCR_IN = i ? 8'hFF : 8'hFE;
      go(1'b1);
      chk("taken", BR_TAKEN, !i);
      chk("pc", PC_OUT, i ? 16'h1002 : 16'h0F82);
      chk("refill", qf, i ? 1 : 3);
      chk("ccr", CCR_OUT, CCR_IN);
    end
    // every n z v c combination for both signed conditions
    for (i = 0; i < 32; i = i + 1) begin
      CCR_IN = {4'h0, i[3:0]};
      BR_OP = i[4] ? `BBC_OP_SIGNED_LE : `BBC_OP_SIGNED_GT;
      go(1'b1);
      chk("signed", BR_TAKEN, (i[2] | (i[3] ^ i[1])) == i[4]);
    end
    // bit clear over every addressing form, legal and refused
    PC_IN = 16'h2000;
    BC_ADDR = 16'h3456;
    BC_MASK = 8'h25;
    CCR_IN = 8'hF3;
    for (i = 0; i < 8; i = i + 1) begin
      BC_MODE = i[2:0];
      rd = i[0] ? 8'h25 : 8'hF0;
      go(1'b0);
      chk("illegal", ILLEGAL, i > 4);
      chk("writes", wr, i < 5);
      chk("reads", rdc, i < 5);
      if (i < 5) begin
        chk("addr", MEM_ADDR, 16'h3456);
        chk("wdata", wd, i[0] ? 8'h00 : 8'hD0);
        chk("ccr", CCR_OUT, i[0] ? 8'hF5 : 8'hF9);
        chk("mask", MASK_ADDR, 16'h2000 + (i == 4 ? 4 : 2 + i[0]));
      end
    end
    finish_test;
  end
  // the run needs well under a thousand cycles
  initial begin
    #40000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule
